// *** rftx_serial_config_port.sv ***
// Serial configuration port, keying and clock output logic of the transmitter.
`timescale 1ns/1ps
`default_nettype none
`include "rftx_cfg_regs.svh"
// Notes on behaviour
// [R01] Select is active low; clock and data count only while select is low.
// [R02] Serial data is sampled on each rising serial clock edge.
// [R03] Host keeps serial clock low at select fall and at select rise.
// [R04] Host keeps serial clock low briefly after select rises.
// [R05] Readback output changes after each falling serial clock edge.
// [R06] Readback output is driven valid once select falls, before any clock edge.
// [R07] Serial clock and data read low when undriven.
// [R08] Enable high runs normally; low or floating means standby.
// [R09] Modulation input keys ASK or FSK as the control register chooses.
// [R10] General output picks readback, clock, modulation echo or low.
// [R11] Clock output is the reference divided by one, two, four or eight.
// [R12] ASK mode transmits on the lower frequency pair.
// [R13] FSK mode picks upper or lower pair from the modulation input.
// [R14] Control bit 0 FSK, bits 2:1 output source, bits 4:3 divider; reset zero.
module rftx_serial_config_port #(
	parameter int BUF_DEPTH = 2
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic selectN,
	input wire logic sclk,
	input wire logic serialIn,
	input wire logic enablePin,
	input wire logic modDataIn,
	input wire logic xtalRef,
	output logic generalOutPin,
	output logic [15:0] txFreqWord,
	output logic paKeyOn,
	output logic standby
);
	// ****************************************
	// Parameter check
	// ****************************************
	// The pointers wrap by bit width, so only powers of two are served.
	if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : gBadDepth
		$error("BUF_DEPTH must be a power of two of at least two.");
	end
	localparam int PW = $clog2(BUF_DEPTH);

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] cfg_r [`RFTX_NUM_REGS];
	rftx_pkg::rftx_frame_t buf_r [BUF_DEPTH];
	logic [PW-1:0] wrPtr_r, rdPtr_r;
	logic [PW:0] level_r;
	rftx_pkg::rftx_state_t state_r;
	logic sclkPrev_r, selPrevN_r, refPrev_r;
	logic [2:0] bitCnt_r;
	logic [7:0] shiftIn_r, addr_r, rbShift_r;
	logic readback_r, ovf_r;
	logic [2:0] refCnt_r;
	logic refSample_r;
	logic dValid_r, dWrite_r;
	logic [7:0] dAddr_r;
	logic [31:0] hrdata_r;
	logic generalOut_r, paKey_r, standby_r;
	logic [15:0] txFreq_r;

	// Index decode shared by serial readback and bus reads.
	function automatic logic [7:0] readReg(input logic [7:0] idx);
		readReg = 8'h00;
		if (idx < `RFTX_NUM_REGS) begin
			readReg = cfg_r[idx[2:0]];
		end
	endfunction

	// ****************************************
	// Serial edge detection
	// ****************************************
	// Pull-ups and pull-downs sit in the pads, so an open select reads high
	// and open clock and data read low here. [R07]
	wire selActive = ~selectN; // [R01]
	wire selFall = selActive & selPrevN_r;
	wire sclkRise = selActive & sclk & ~sclkPrev_r; // [R02]
	wire sclkFall = selActive & ~sclk & sclkPrev_r;
	wire [7:0] byteIn = {shiftIn_r[6:0], serialIn};
	wire byteDone = sclkRise & (bitCnt_r == 3'h7);
	wire isRead = byteIn[`RFTX_ADDR_RD_BIT];
	wire [7:0] nextIdx = addr_r + 8'h01;

	// Input history for edge detection.
	always_ff @(posedge mclk) begin
		if (rst) begin
			sclkPrev_r <= 1'b0;
			selPrevN_r <= 1'b1;
		end else begin
			sclkPrev_r <= sclk;
			selPrevN_r <= selectN;
		end
	end

	// ****************************************
	// Receive sequencer
	// ****************************************
	// A frame is an address byte then data bytes; the index steps per byte.
	// The host parks the clock low around select edges, so no edge is
	// mistaken at either end of a frame. [R03] [R04]
	always_ff @(posedge mclk) begin
		if (rst || !selActive) begin
			state_r <= rftx_pkg::RFTX_IDLE;
			bitCnt_r <= 3'h0;
			shiftIn_r <= 8'h00;
			addr_r <= 8'h00;
		end else if (selFall) begin
			state_r <= rftx_pkg::RFTX_ADDR;
			bitCnt_r <= 3'h0;
		end else if (sclkRise) begin
			shiftIn_r <= byteIn; // [R02]
			bitCnt_r <= bitCnt_r + 3'h1;
			if (byteDone) begin
				unique case (state_r)
					rftx_pkg::RFTX_ADDR: begin
						addr_r <= {1'b0, byteIn[6:0]};
						state_r <= isRead ? rftx_pkg::RFTX_RDATA : rftx_pkg::RFTX_WDATA;
					end
					rftx_pkg::RFTX_WDATA, rftx_pkg::RFTX_RDATA: begin
						addr_r <= nextIdx;
					end
					rftx_pkg::RFTX_IDLE: begin
						state_r <= rftx_pkg::RFTX_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Readback shifter
	// ****************************************
	wire loadFirst = byteDone && state_r == rftx_pkg::RFTX_ADDR && isRead;
	wire loadNext = byteDone && state_r == rftx_pkg::RFTX_RDATA;
	wire [7:0] firstByte = readReg({1'b0, byteIn[6:0]});
	wire [7:0] nextByte = readReg(nextIdx);

	// The output is cleared at select fall so it is valid before any edge,
	// and moves only on falling edges so the host samples it on rising ones.
	always_ff @(posedge mclk) begin
		if (rst || !selActive) begin
			rbShift_r <= 8'h00;
			readback_r <= 1'b0;
		end else if (selFall) begin
			readback_r <= 1'b0; // [R06]
		end else if (loadFirst) begin
			rbShift_r <= firstByte;
		end else if (loadNext) begin
			rbShift_r <= nextByte;
		end else if (sclkFall) begin
			readback_r <= rbShift_r[7]; // [R05]
			rbShift_r <= {rbShift_r[6:0], 1'b0};
		end
	end

	// ****************************************
	// Two-entry write buffer
	// ****************************************
	wire pushReq = byteDone && state_r == rftx_pkg::RFTX_WDATA;
	wire bufReady = (level_r != (PW+1)'(BUF_DEPTH));
	wire bufValid = (level_r != '0);
	wire push = pushReq & bufReady;
	wire [7:0] busIdx = dAddr_r >> 2;
	wire busCfgWr = dValid_r & dWrite_r & (busIdx < `RFTX_NUM_REGS);
	// A bus write to a configuration register owns the register port for its cycle and stalls the drain.
	wire drainReady = ~busCfgWr;
	wire pop = bufValid & drainReady;
	rftx_pkg::rftx_frame_t head;
	assign head = buf_r[rdPtr_r];

	// Buffer storage and pointers.
	always_ff @(posedge mclk) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			level_r <= '0;
		end else begin
			if (push) begin
				buf_r[wrPtr_r] <= '{addr: addr_r, data: byteIn};
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			level_r <= level_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	// The serial link cannot be held off, so a byte that meets a full
	// buffer is dropped and flagged; a new drop beats a clear.
	wire statusWr = dValid_r & dWrite_r & (dAddr_r == `RFTX_AHB_STATUS);
	wire ovfClr = statusWr & hwdata[`RFTX_ST_OVF];

	// Bus writes first, then drained serial writes; out-of-range drops.
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < `RFTX_NUM_REGS; i++) begin
				cfg_r[i] <= `RFTX_CFG_RESET; // [R14]
			end
			ovf_r <= 1'b0;
		end else begin
			if (busCfgWr) begin
				cfg_r[busIdx[2:0]] <= hwdata[7:0];
			end else if (pop && head.addr < `RFTX_NUM_REGS) begin
				cfg_r[head.addr[2:0]] <= head.data;
			end
			ovf_r <= (pushReq & ~bufReady) | (ovf_r & ~ovfClr);
		end
	end

	// ****************************************
	// Reference divider
	// ****************************************
	wire [7:0] ctrl = cfg_r[`RFTX_IDX_CTRL];
	wire modeFsk = ctrl[`RFTX_CTRL_FSK];
	wire [1:0] divSel = ctrl[`RFTX_CTRL_DIV_LSB +: 2];
	rftx_pkg::rftx_src_t srcSel;
	assign srcSel = rftx_pkg::rftx_src_t'(ctrl[`RFTX_CTRL_SRC_LSB +: 2]);
	wire refRise = xtalRef & ~refPrev_r;
	// Divide by one passes the sampled reference; each counter bit halves it.
	wire clockOut = (divSel == 2'h0) ? refSample_r : refCnt_r[divSel - 2'h1]; // [R11]

	// Reference edge counter; it stops in standby.
	always_ff @(posedge mclk) begin
		if (rst) begin
			refPrev_r <= 1'b0;
			refSample_r <= 1'b0;
			refCnt_r <= 3'h0;
		end else begin
			refPrev_r <= xtalRef;
			refSample_r <= xtalRef;
			if (refRise && enablePin) begin
				refCnt_r <= refCnt_r + 3'h1;
			end
		end
	end

	// ****************************************
	// Keying and output selection
	// ****************************************
	wire [15:0] upperWord = {cfg_r[`RFTX_IDX_UP_HI], cfg_r[`RFTX_IDX_UP_LO]};
	wire [15:0] lowerWord = {cfg_r[`RFTX_IDX_LO_HI], cfg_r[`RFTX_IDX_LO_LO]};
	// ASK always uses the lower pair, FSK steers on the data level. [R12] [R13]
	wire [15:0] freqNxt = (modeFsk & modDataIn) ? upperWord : lowerWord;
	// ASK gates the carrier with the data; FSK keeps it on. [R09]
	wire keyNxt = enablePin & (modeFsk | modDataIn); // [R08]
	logic outNxt;
	// Output source mux; only the clock source is gated by standby.
	always_comb begin
		unique case (srcSel) // [R10]
			rftx_pkg::RFTX_SRC_READBACK: outNxt = readback_r;
			rftx_pkg::RFTX_SRC_CLOCK: outNxt = clockOut & enablePin;
			rftx_pkg::RFTX_SRC_MODDATA: outNxt = modDataIn;
			rftx_pkg::RFTX_SRC_LOW: outNxt = 1'b0;
		endcase
	end

	// Registered transmitter and pin outputs.
	always_ff @(posedge mclk) begin
		if (rst) begin
			txFreq_r <= 16'h0000;
			paKey_r <= 1'b0;
			standby_r <= 1'b1;
			generalOut_r <= 1'b0;
		end else begin
			txFreq_r <= freqNxt;
			paKey_r <= keyNxt;
			standby_r <= ~enablePin; // [R08]
			generalOut_r <= outNxt;
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************
	wire addrPhase = hsel & hready & htrans[1];
	wire [7:0] rdIdx = haddr[7:0] >> 2;
	wire [31:0] statusWord = {26'h0, level_r[1:0] & 2'(level_r), 1'b0,
		selActive, ovf_r, enablePin};
	// Read data is fetched in the address phase so it leaves a flip-flop.
	// Only the lowest page decodes, so an alias of the status word reads zero.
	wire lowPage = (haddr[31:8] == 24'h0);
	wire [31:0] rdNxt = !lowPage ? 32'h0 : (haddr[7:0] == `RFTX_AHB_STATUS) ? statusWord :
		(haddr[1:0] == 2'h0) ? {24'h0, readReg(rdIdx)} : 32'h0;

	// Address phase capture and read data.
	always_ff @(posedge mclk) begin
		if (rst) begin
			dValid_r <= 1'b0;
			dWrite_r <= 1'b0;
			dAddr_r <= 8'h00;
			hrdata_r <= 32'h0;
		end else begin
			dValid_r <= addrPhase & (haddr[31:8] == 24'h0);
			dWrite_r <= hwrite;
			dAddr_r <= haddr[7:0];
			if (addrPhase && !hwrite) begin
				hrdata_r <= rdNxt;
			end
		end
	end

	// The slave never waits and never errors.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign generalOutPin = generalOut_r;
	assign txFreqWord = txFreq_r;
	assign paKeyOn = paKey_r;
	assign standby = standby_r;
endmodule
`default_nettype wire

// *** rftx_cfg_regs.svh ***
// Register indices, field positions, bus offsets and reset values of the transmitter configuration port.
`ifndef RFTX_CFG_REGS_SVH
`define RFTX_CFG_REGS_SVH
// ****************************************
// Serial register indices
// ****************************************
`define RFTX_IDX_CTRL 3'h0
`define RFTX_IDX_UP_HI 3'h1
`define RFTX_IDX_UP_LO 3'h2
`define RFTX_IDX_LO_HI 3'h3
`define RFTX_IDX_LO_LO 3'h4
`define RFTX_NUM_REGS 5
`define RFTX_CFG_RESET 8'h00
// ****************************************
// Control register fields
// ****************************************
`define RFTX_CTRL_FSK 0
`define RFTX_CTRL_SRC_LSB 1
`define RFTX_CTRL_DIV_LSB 3
// Serial frame: top address bit set means read.
`define RFTX_ADDR_RD_BIT 7
// ****************************************
// Bus byte offset and status word bit positions
// ****************************************
`define RFTX_AHB_STATUS 8'h14
`define RFTX_ST_ENABLE 0
`define RFTX_ST_OVF 1
`define RFTX_ST_SELECT 2
`define RFTX_ST_LVL_LSB 4
`endif

// *** rftx_pkg.sv ***
// Types shared by the transmitter configuration port.
package rftx_pkg;
	// Receive sequencer states.
	typedef enum logic [1:0] {
		RFTX_IDLE = 2'b00,
		RFTX_ADDR = 2'b01,
		RFTX_WDATA = 2'b10,
		RFTX_RDATA = 2'b11
	} rftx_state_t;
	// Source on the general-purpose output.
	typedef enum logic [1:0] {
		RFTX_SRC_READBACK = 2'b00,
		RFTX_SRC_CLOCK = 2'b01,
		RFTX_SRC_MODDATA = 2'b10,
		RFTX_SRC_LOW = 2'b11
	} rftx_src_t;
	// One received write: register index and byte.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rftx_frame_t;
endpackage

// *** rftx_cfg_props.sv ***
// Port checker for the transmitter configuration port.
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module rftx_cfg_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic enablePin,
	input wire logic modDataIn,
	input wire logic paKeyOn,
	input wire logic standby
);
	// A read is taken only in an accepted address phase.
	wire rdPhase = hsel && hready && htrans[1] && !hwrite;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// The first edge after reset still sees reset-time outputs, so it is skipped.
	ready_okay_a: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
	standby_follow_a: assert property (!$past(rst) |-> standby == !$past(enablePin)) else $error("standby wrong");
	key_off_a: assert property (!$past(rst) && !$past(enablePin) |-> !paKeyOn) else $error("key in standby");
	key_on_a: assert property (!$past(rst) && $past(enablePin) && $past(modDataIn) |-> paKeyOn) else $error("no key");
	unmapped_zero_a: assert property (rdPhase && haddr > 32'h14 |=> hrdata == 32'h0) else $error("unmapped data");
	cfg_width_a: assert property (rdPhase && haddr < 32'h14 |=> hrdata[31:8] == 24'h0) else $error("cfg width");
	status_width_a: assert property (rdPhase && haddr == 32'h14 |=> hrdata[31:6] == 26'h0) else $error("status");
	rdata_hold_a: assert property (!rdPhase |=> $stable(hrdata)) else $error("read data moved");
	cover property (rdPhase);
	cover property ($past(enablePin) && $past(modDataIn) && paKeyOn);
	cover property ($fell(standby));
endmodule
bind rftx_serial_config_port rftx_cfg_props i_props (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.enablePin(enablePin), .modDataIn(modDataIn), .paKeyOn(paKeyOn), .standby(standby));
`default_nettype wire

// *** rftx_host_model.sv ***
// Host controller model driving the serial configuration pins.
`timescale 1ns/1ps
`default_nettype none
// ********
// Host model
// ********
module rftx_host_model (
	input wire logic mclk,
	input wire logic generalOutPin,
	output logic selectN,
	output logic sclk,
	output logic serialIn
);
	logic pinAtStart;
	// Idle pins rest at their pulled levels.
	initial begin
		selectN = 1'b1;
		sclk = 1'b0;
		serialIn = 1'b0;
		pinAtStart = 1'b0;
	end
	// Four cycles per level, since the port samples pins on mclk.
	task automatic hold;
		repeat (4) @(posedge mclk);
	endtask
	// One address and one data byte, MSB first; sel low leaves the port deselected.
	task automatic frame(input logic sel, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rb);
		logic [15:0] sh;
		sh = {a, d};
		rb = 8'h00;
		selectN <= !sel;
		hold();
		pinAtStart = generalOutPin;
		for (int i = 15; i >= 0; i--) begin
			serialIn <= sh[i];
			hold();
			sclk <= 1'b1;
			hold();
			sclk <= 1'b0;
			hold();
			if (i >= 1 && i <= 8) rb[i - 1] = generalOutPin;
		end
		selectN <= 1'b1;
		serialIn <= 1'b0;
		hold();
	endtask
endmodule
`default_nettype wire

// *** rftx_serial_config_port_tb.sv ***
// Self-checking testbench of the transmitter configuration port.
`timescale 1ns/1ps
`default_nettype none
// ********
// Testbench
// ********
module rftx_serial_config_port_tb;
	logic mclk, rst, hsel, hwrite, enablePin, modDataIn, xtalRef, prev;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hready, hreadyout, hresp, generalOutPin, paKeyOn, standby, selectN, sclk, serialIn;
	logic [15:0] txFreqWord;
	logic [7:0] rb;
	int err_count, checked, cnt;
	assign hready = hreadyout;
	rftx_serial_config_port i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .selectN(selectN), .sclk(sclk), .serialIn(serialIn),
		.enablePin(enablePin), .modDataIn(modDataIn), .xtalRef(xtalRef), .generalOutPin(generalOutPin),
		.txFreqWord(txFreqWord), .paKeyOn(paKeyOn), .standby(standby));
	rftx_host_model i_host (.mclk(mclk), .generalOutPin(generalOutPin), .selectN(selectN), .sclk(sclk),
		.serialIn(serialIn));
	// Clocks: 100 MHz system clock and a slower reference.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		xtalRef = 1'b0;
		forever #40 xtalRef = ~xtalRef;
	end
	task stop_test;
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait, so a stuck slave ends the run instead of hanging it.
	task waitRdy;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			err_count++;
			stop_test();
		end
	endtask
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitRdy();
		rd = hrdata;
	endtask
	// Main sequence.
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		enablePin = 1'b0;
		modDataIn = 1'b0;
		err_count = 0;
		checked = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			ahb(1'b0, i * 4, 32'h0);
			chk(rd, 32'h0);
		end
		for (int i = 1; i < 5; i++) ahb(1'b1, i * 4, 32'hA0 + i);
		ahb(1'b1, 32'h18, 32'h77);
		for (int i = 1; i < 6; i++) begin
			ahb(1'b0, i * 4 + 4 * (i / 5), 32'h0);
			chk(rd, i < 5 ? 32'hA0 + i : 32'h0);
		end
		i_host.frame(1'b1, 8'h03, 8'h5C, rb);
		i_host.frame(1'b0, 8'h04, 8'hFF, rb);
		ahb(1'b0, 32'h0C, 32'h0);
		chk(rd, 32'h5C);
		ahb(1'b0, 32'h10, 32'h0);
		chk(rd, 32'hA4);
		i_host.frame(1'b1, 8'h81, 8'h00, rb);
		chk(rb, 8'hA1);
		chk(i_host.pinAtStart, 1'b0);
		enablePin <= 1'b1;
		for (int f = 0; f < 2; f++) begin
			ahb(1'b1, 32'h0, f);
			for (int m = 0; m < 2; m++) begin
				modDataIn <= m[0];
				repeat (3) @(posedge mclk);
				chk(txFreqWord, f && m ? 16'hA1A2 : 16'h5CA4);
				chk(paKeyOn, f || m);
			end
		end
		enablePin <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({standby, paKeyOn}, 2'b10);
		enablePin <= 1'b1;
		ahb(1'b1, 32'h0, 32'h04);
		repeat (3) @(posedge mclk);
		chk({standby, generalOutPin}, 2'b01);
		ahb(1'b1, 32'h0, 32'h06);
		repeat (3) @(posedge mclk);
		chk(generalOutPin, 1'b0);
		// Rising edges over 80 reference periods give 80 divided by the ratio.
		for (int d = 0; d < 4; d++) begin
			ahb(1'b1, 32'h0, (d << 3) | 2);
			cnt = 0;
			prev = generalOutPin;
			repeat (640) begin
				@(posedge mclk);
				if (generalOutPin && !prev) cnt++;
				prev = generalOutPin;
			end
			chk(cnt > (80 >> d) - 2 && cnt < (80 >> d) + 2, 1'b1);
		end
		ahb(1'b0, 32'h14, 32'h0);
		chk(rd, 32'h1);
		stop_test();
	end
endmodule
`default_nettype wire
